// >>> image_port.v
/*
  image port output stage: video fifo with fill flags, two-section text buffer,
  video/text arbiter, byte serializer with reference codes and reference pins.
  assumes scaler, slicer and the register port on mclk; port_clk and the gating
  input come from the attached party and are sampled here.
*/
// Operation
// - video fifo of 32 double words sits behind the scaler.
// - port steps on every clock or on rising edges of the external port clock.
// - four fifo flags: almost empty, combined filled, almost full, overflow.
// - combined flag sets at almost full, clears below almost empty, or at empty when almost empty is set to empty.
// - level register selects almost full 16/24/28/full and almost empty 16/8/4/empty.
// - any fifo flag or the marker can be routed to either general pin.
// - text buffer has two sections; whole lines go out gap free.
// - each sliced line leads with a header holding line number and standard.
// - identifier below 3Eh uses ancillary header, 3Eh or 3Fh uses codes.
// - sliced marker sets on first ancillary byte, clears on start code.
// - remap on turns 00h and FFh into 03h and FCh.
// - text goes out only between video lines with the video fifo empty.
// - reference pins show gates or one-step pulses on gate rising edges.
// - qualifier marks valid bytes; idle cycles carry 00h.
// - timing reference codes can be dropped from the stream.
// - external gate holds output; the port stalls and then resumes.
// - qualifier and reference pins have selectable polarity, default active high.
// - start of active line codes 0E/49 or 80/C7.
// - end of non-last active line codes 13/54 or 9D/DA.
// - end of last active or blanking line codes 38/7F or B6/F1.
// - every code byte is led by FFh, 00h, 00h.
`timescale 1ns/1ns
`include "img_port_consts.vh"

module stream_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk,
  input wire rst,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready,
  output wire [AW:0] count
);
  // depth must be a power of two so that the pointers wrap by themselves
  localparam [AW:0] FULL_CNT = DEPTH;
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ff;
  reg [AW-1:0] rd_ff;
  reg [AW:0] cnt_ff;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  assign in_ready = (cnt_ff != FULL_CNT);
  assign out_valid = (cnt_ff != {(AW+1){1'b0}});
  assign out_data = mem[rd_ff];
  assign count = cnt_ff;

  always @(posedge clk) begin
    if (push) begin
      mem[wr_ff] <= in_data;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      wr_ff <= {AW{1'b0}};
      rd_ff <= {AW{1'b0}};
      cnt_ff <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ff <= wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= rd_ff + 1'b1;
      end
      if (push & ~pop) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (pop & ~push) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end
endmodule // stream_fifo

module image_port_fifo_and_reference_coding #(
  parameter VDEPTH = `VFIFO_DEPTH,
  parameter VAW = 5,
  parameter TSEC = `TXT_SEC_LEN,
  parameter TAW = 6
) (
  input wire mclk,
  input wire srst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  output reg [7:0] reg_rdata_ff,
  input wire ext_clk_mode,
  input wire port_clk,
  input wire gate_use,
  input wire external_gate_input,
  input wire codes_off,
  input wire ref_pulse_mode,
  input wire sliced_value_remap,
  input wire [5:0] sliced_header_identifier,
  input wire video_code_msb,
  input wire [2:0] pin_a_sel,
  input wire [2:0] pin_b_sel,
  input wire [4:0] out_invert,
  input wire [31:0] scl_dw,
  input wire scl_first,
  input wire scl_last,
  input wire scl_fid,
  input wire scl_vact,
  input wire scl_lastline,
  input wire scl_valid,
  output reg scl_ready_ff,
  input wire [7:0] txt_byte,
  input wire txt_valid,
  input wire txt_line_done,
  input wire [8:0] txt_line_num,
  input wire [3:0] txt_std,
  input wire txt_fid,
  output reg txt_ready_ff,
  output reg [7:0] pdata_ff,
  output reg output_qualifier_pin,
  output reg horizontal_ref_pin,
  output reg vertical_ref_pin,
  output reg general_output_pin_a,
  output reg general_output_pin_b
);
  localparam [5:0] S_IDLE = 6'b000001;
  localparam [5:0] S_LEAD = 6'b000010;
  localparam [5:0] S_CODE = 6'b000100;
  localparam [5:0] S_VID = 6'b001000;
  localparam [5:0] S_THDR = 6'b010000;
  localparam [5:0] S_TXT = 6'b100000;
  localparam [TAW:0] TSEC_W = TSEC;
  localparam [VAW:0] VSLACK = VDEPTH - 1;
  localparam [VAW:0] VFULL = VDEPTH;

  function [7:0] trc;
    input [1:0] kind;
    input msb;
    input fid;
    begin
      case ({kind, msb, fid})
        4'h0: trc = `TRC_SAV_ACT_00;
        4'h1: trc = `TRC_SAV_ACT_01;
        4'h2: trc = `TRC_SAV_ACT_10;
        4'h3: trc = `TRC_SAV_ACT_11;
        4'h4: trc = `TRC_EAV_ACT_00;
        4'h5: trc = `TRC_EAV_ACT_01;
        4'h6: trc = `TRC_EAV_ACT_10;
        4'h7: trc = `TRC_EAV_ACT_11;
        4'h8: trc = `TRC_SAV_BLK_00;
        4'h9: trc = `TRC_SAV_BLK_01;
        4'hA: trc = `TRC_SAV_BLK_10;
        4'hB: trc = `TRC_SAV_BLK_11;
        4'hC: trc = `TRC_EAV_BLK_00;
        4'hD: trc = `TRC_EAV_BLK_01;
        4'hE: trc = `TRC_EAV_BLK_10;
        default: trc = `TRC_EAV_BLK_11;
      endcase
    end
  endfunction

  // link sampling
  reg pclk_m_ff, pclk_s_ff, pclk_d_ff, gate_m_ff, gate_s_ff;
  always @(posedge mclk) begin
    if (srst) begin
      pclk_m_ff <= 1'b0;
      pclk_s_ff <= 1'b0;
      pclk_d_ff <= 1'b0;
      gate_m_ff <= 1'b0;
      gate_s_ff <= 1'b0;
    end else begin
      pclk_m_ff <= port_clk;
      pclk_s_ff <= pclk_m_ff;
      pclk_d_ff <= pclk_s_ff;
      gate_m_ff <= external_gate_input;
      gate_s_ff <= gate_m_ff;
    end
  end
  wire tick = ext_clk_mode ? (pclk_s_ff & ~pclk_d_ff) : 1'b1;
  wire go = tick & (~gate_use | gate_s_ff);

  // video fifo
  wire [36:0] vf_out;
  wire vf_out_valid, vf_in_ready;
  wire [VAW:0] vcount;
  reg vpop;
  stream_fifo #(.WIDTH(37), .DEPTH(VDEPTH), .AW(VAW)) u_vfifo (
    .clk(mclk),
    .rst(srst),
    .in_data({scl_first, scl_last, scl_fid, scl_vact, scl_lastline, scl_dw}),
    .in_valid(scl_valid),
    .in_ready(vf_in_ready),
    .out_data(vf_out),
    .out_valid(vf_out_valid),
    .out_ready(vpop),
    .count(vcount)
  );

  // level register and flags
  reg [3:0] lvl_ff;
  reg ae_ff, fill_ff, af_ff, ovf_ff, mark_ff;
  reg [5:0] af_lvl, ae_lvl;
  wire [1:0] af_fld = lvl_ff[`AF_FLD_LSB+1:`AF_FLD_LSB];
  wire [1:0] ae_fld = lvl_ff[`AE_FLD_LSB+1:`AE_FLD_LSB];
  wire lvl_wr = reg_wr & (reg_addr == `REG_FLAG_LEVELS);
  wire [5:0] vcnt6 = vcount;
  wire at_af = (vcnt6 >= af_lvl);
  wire below_ae = (vcnt6 < ae_lvl) | ((ae_fld == 2'h3) & (vcnt6 == 6'h00));
  always @* begin
    case (af_fld)
      2'h0: af_lvl = `AF_LVL_0;
      2'h1: af_lvl = `AF_LVL_1;
      2'h2: af_lvl = `AF_LVL_2;
      default: af_lvl = VFULL;
    endcase
    case (ae_fld)
      2'h0: ae_lvl = `AE_LVL_0;
      2'h1: ae_lvl = `AE_LVL_1;
      2'h2: ae_lvl = `AE_LVL_2;
      default: ae_lvl = `AE_LVL_3;
    endcase
  end
  always @(posedge mclk) begin
    if (srst) begin
      lvl_ff <= `REG_FLAG_LEVELS_RST;
      ae_ff <= 1'b1;
      fill_ff <= 1'b0;
      af_ff <= 1'b0;
      ovf_ff <= 1'b0;
      reg_rdata_ff <= 8'h00;
      scl_ready_ff <= 1'b0;
    end else begin
      if (lvl_wr) begin
        lvl_ff <= reg_wdata[3:0];
      end
      ae_ff <= (vcnt6 <= ae_lvl);
      af_ff <= at_af;
      if (at_af) begin
        fill_ff <= 1'b1;
      end else if (below_ae) begin
        fill_ff <= 1'b0;
      end
      if (scl_valid & ~vf_in_ready) begin
        ovf_ff <= 1'b1;
      end else if (lvl_wr & reg_wdata[`OVF_CLR_BIT]) begin
        ovf_ff <= 1'b0;
      end
      if (reg_addr == `REG_FLAG_LEVELS) begin
        reg_rdata_ff <= {ovf_ff, af_ff, fill_ff, ae_ff, lvl_ff};
      end else begin
        reg_rdata_ff <= 8'h00;
      end
      // one spare entry absorbs the word taken in the cycle ready falls
      scl_ready_ff <= (vcount < VSLACK);
    end
  end

  // text buffer, two sections
  reg [7:0] tmem [0:2*TSEC-1];
  reg [TAW:0] slen_ff [0:1];
  reg [13:0] shdr_ff [0:1];
  reg [1:0] sec_full_ff, nxt_full;
  reg wsec_ff, rsec_ff, nxt_wsec, trel;
  reg [TAW:0] wcnt_ff;
  wire wr_ok = ~sec_full_ff[wsec_ff];
  always @(posedge mclk) begin
    if (txt_valid & wr_ok & (wcnt_ff < TSEC_W)) begin
      tmem[{wsec_ff, wcnt_ff[TAW-1:0]}] <= txt_byte;
    end
    if (txt_line_done & wr_ok) begin
      slen_ff[wsec_ff] <= wcnt_ff;
      shdr_ff[wsec_ff] <= {txt_line_num, txt_std, txt_fid};
    end
  end
  always @* begin
    nxt_full = sec_full_ff;
    nxt_wsec = wsec_ff;
    if (txt_line_done & wr_ok) begin
      nxt_full[wsec_ff] = 1'b1;
      nxt_wsec = ~wsec_ff;
    end
    if (trel) begin
      nxt_full[rsec_ff] = 1'b0;
    end
  end
  always @(posedge mclk) begin
    if (srst) begin
      sec_full_ff <= 2'b00;
      wsec_ff <= 1'b0;
      rsec_ff <= 1'b0;
      wcnt_ff <= {(TAW+1){1'b0}};
      txt_ready_ff <= 1'b0;
    end else begin
      sec_full_ff <= nxt_full;
      wsec_ff <= nxt_wsec;
      txt_ready_ff <= ~nxt_full[nxt_wsec];
      if (trel) begin
        rsec_ff <= ~rsec_ff;
      end
      if (txt_line_done & wr_ok) begin
        wcnt_ff <= {(TAW+1){1'b0}};
      end else if (txt_valid & wr_ok & (wcnt_ff < TSEC_W)) begin
        wcnt_ff <= wcnt_ff + 1'b1;
      end
    end
  end

  // serializer
  reg [5:0] st_ff, ret_ff;
  reg [1:0] cnt_ff, bidx_ff;
  reg [2:0] hidx_ff;
  reg [TAW-1:0] ridx_ff;
  reg [36:0] cur_ff;
  reg [7:0] code_ff;
  reg in_line_ff, vact_ff, fid_ff;
  wire [5:0] hid = sliced_header_identifier;
  wire hid_codes = (hid >= `HID_CODES_MIN);
  wire hid_msb = (hid == `HID_MSB_ONE);
  wire [TAW:0] tlen = slen_ff[rsec_ff];
  wire [13:0] thdr = shdr_ff[rsec_ff];
  wire tlast = ({1'b0, ridx_ff} + 1'b1) == tlen;
  wire txt_avail = sec_full_ff[rsec_ff] & ~vf_out_valid & ~in_line_ff;
  wire [7:0] raw = tmem[{rsec_ff, ridx_ff}];
  wire [6:0] idi1_lo = {thdr[0], thdr[13:8]};
  wire [6:0] idi2_lo = {thdr[7:5], thdr[4:1]};
  reg [7:0] hdr_byte, txt_out;

  always @* begin
    case (hidx_ff)
      3'h0: hdr_byte = `ANC_FIRST;
      3'h1: hdr_byte = `ANC_NEXT;
      3'h2: hdr_byte = `ANC_NEXT;
      3'h3: hdr_byte = {~(^hid), ^hid, hid};
      3'h4: hdr_byte = {~(^idi1_lo), idi1_lo};
      default: hdr_byte = {~(^idi2_lo), idi2_lo};
    endcase
    txt_out = raw;
    if (sliced_value_remap & (raw == `REMAP_LOW_IN)) begin
      txt_out = `REMAP_LOW_OUT;
    end else if (sliced_value_remap & (raw == `REMAP_HIGH_IN)) begin
      txt_out = `REMAP_HIGH_OUT;
    end
    vpop = go & vf_out_valid &
      ((st_ff == S_IDLE) | ((st_ff == S_VID) & (bidx_ff == 2'h3) & ~cur_ff[35]));
    trel = go & (((st_ff == S_TXT) & tlast) |
      ((st_ff == S_THDR) & (hidx_ff == 3'h5) & (tlen == {(TAW+1){1'b0}})));
  end

  always @(posedge mclk) begin
    if (srst) begin
      st_ff <= S_IDLE;
      ret_ff <= S_IDLE;
      cnt_ff <= 2'h0;
      bidx_ff <= 2'h0;
      hidx_ff <= 3'h0;
      ridx_ff <= {TAW{1'b0}};
      cur_ff <= 37'h0_0000_0000;
      code_ff <= 8'h00;
      in_line_ff <= 1'b0;
      vact_ff <= 1'b0;
      fid_ff <= 1'b0;
      mark_ff <= 1'b0;
      pdata_ff <= `IDLE_BYTE;
      output_qualifier_pin <= 1'b0;
    end else if (tick) begin
      pdata_ff <= `IDLE_BYTE;
      output_qualifier_pin <= out_invert[0];
      if (go) begin
        case (st_ff)
          S_IDLE: begin
            if (vf_out_valid) begin
              cur_ff <= vf_out;
              bidx_ff <= 2'h0;
              st_ff <= S_VID;
              if (vf_out[36] & ~in_line_ff) begin
                in_line_ff <= 1'b1;
                vact_ff <= vf_out[33];
                fid_ff <= vf_out[34];
                if (~codes_off) begin
                  code_ff <= trc(vf_out[33] ? `KIND_SAV_ACT : `KIND_SAV_BLK,
                    video_code_msb, vf_out[34]);
                  ret_ff <= S_VID;
                  cnt_ff <= 2'h0;
                  st_ff <= S_LEAD;
                end
              end
            end else if (txt_avail) begin
              ridx_ff <= {TAW{1'b0}};
              if (~hid_codes) begin
                hidx_ff <= 3'h0;
                st_ff <= S_THDR;
              end else begin
                hidx_ff <= 3'h4;
                st_ff <= S_THDR;
                if (~codes_off) begin
                  code_ff <= trc(`KIND_SAV_BLK, hid_msb, thdr[0]);
                  ret_ff <= S_THDR;
                  cnt_ff <= 2'h0;
                  st_ff <= S_LEAD;
                end
              end
            end
          end
          S_LEAD: begin
            pdata_ff <= (cnt_ff == 2'h0) ? `LEAD_FIRST : `LEAD_NEXT;
            output_qualifier_pin <= ~out_invert[0];
            cnt_ff <= cnt_ff + 1'b1;
            if (cnt_ff == 2'h2) begin
              st_ff <= S_CODE;
            end
          end
          S_CODE: begin
            pdata_ff <= code_ff;
            output_qualifier_pin <= ~out_invert[0];
            st_ff <= ret_ff;
            if (ret_ff != S_IDLE) begin
              mark_ff <= 1'b0;
            end
          end
          S_VID: begin
            pdata_ff <= cur_ff[8*bidx_ff +: 8];
            output_qualifier_pin <= ~out_invert[0];
            bidx_ff <= bidx_ff + 1'b1;
            if (bidx_ff == 2'h3) begin
              if (cur_ff[35]) begin
                in_line_ff <= 1'b0;
                st_ff <= S_IDLE;
                if (~codes_off) begin
                  code_ff <= trc((vact_ff & ~cur_ff[32]) ? `KIND_EAV_ACT : `KIND_EAV_BLK,
                    video_code_msb, fid_ff);
                  ret_ff <= S_IDLE;
                  cnt_ff <= 2'h0;
                  st_ff <= S_LEAD;
                end
              end else if (vf_out_valid) begin
                cur_ff <= vf_out;
              end else begin
                st_ff <= S_IDLE;
              end
            end
          end
          S_THDR: begin
            pdata_ff <= hdr_byte;
            output_qualifier_pin <= ~out_invert[0];
            hidx_ff <= hidx_ff + 1'b1;
            if (hidx_ff == 3'h0) begin
              mark_ff <= 1'b1;
            end
            if (hidx_ff == 3'h5) begin
              st_ff <= S_TXT;
              if (tlen == {(TAW+1){1'b0}}) begin
                st_ff <= S_IDLE;
                if (hid_codes & ~codes_off) begin
                  code_ff <= trc(`KIND_EAV_BLK, hid_msb, thdr[0]);
                  ret_ff <= S_IDLE;
                  cnt_ff <= 2'h0;
                  st_ff <= S_LEAD;
                end
              end
            end
          end
          S_TXT: begin
            pdata_ff <= txt_out;
            output_qualifier_pin <= ~out_invert[0];
            ridx_ff <= ridx_ff + 1'b1;
            if (tlast) begin
              st_ff <= S_IDLE;
              if (hid_codes & ~codes_off) begin
                code_ff <= trc(`KIND_EAV_BLK, hid_msb, thdr[0]);
                ret_ff <= S_IDLE;
                cnt_ff <= 2'h0;
                st_ff <= S_LEAD;
              end
            end
          end
          default: st_ff <= S_IDLE;
        endcase
      end
    end
  end

  // reference and general pins
  reg h_prev_ff, v_prev_ff;
  wire v_gate = in_line_ff & vact_ff;
  reg [4:0] flag_vec;
  always @* begin
    flag_vec = {mark_ff, ovf_ff, af_ff, fill_ff, ae_ff};
  end
  always @(posedge mclk) begin
    if (srst) begin
      h_prev_ff <= 1'b0;
      v_prev_ff <= 1'b0;
      horizontal_ref_pin <= 1'b0;
      vertical_ref_pin <= 1'b0;
      general_output_pin_a <= 1'b0;
      general_output_pin_b <= 1'b0;
    end else begin
      if (tick) begin
        h_prev_ff <= in_line_ff;
        v_prev_ff <= v_gate;
        horizontal_ref_pin <= out_invert[1] ^
          (ref_pulse_mode ? (in_line_ff & ~h_prev_ff) : in_line_ff);
        vertical_ref_pin <= out_invert[2] ^
          (ref_pulse_mode ? (v_gate & ~v_prev_ff) : v_gate);
      end
      general_output_pin_a <= out_invert[3] ^
        ((pin_a_sel <= `SEL_MARK) ? flag_vec[pin_a_sel] : 1'b0);
      general_output_pin_b <= out_invert[4] ^
        ((pin_b_sel <= `SEL_MARK) ? flag_vec[pin_b_sel] : 1'b0);
    end
  end
endmodule // image_port_fifo_and_reference_coding

// >>> img_port_consts.vh
/*
  constants of the image port output stage: register offset and fields, fill levels,
  lead-in and header bytes, timing reference codes, value remapping, buffer sizes.
  assumes inclusion by bare name from the design file.
*/
`ifndef IMG_PORT_CONSTS_VH
`define IMG_PORT_CONSTS_VH

`define REG_FLAG_LEVELS 8'h86
`define REG_FLAG_LEVELS_RST 4'h0
`define AE_FLD_LSB 0
`define AF_FLD_LSB 2
`define OVF_CLR_BIT 4
`define RD_AE_BIT 4
`define RD_FILL_BIT 5
`define RD_AF_BIT 6
`define RD_OVF_BIT 7

`define VFIFO_DEPTH 32
`define TXT_SEC_LEN 64

`define AF_LVL_0 6'h10
`define AF_LVL_1 6'h18
`define AF_LVL_2 6'h1C
`define AE_LVL_0 6'h10
`define AE_LVL_1 6'h08
`define AE_LVL_2 6'h04
`define AE_LVL_3 6'h00

`define IDLE_BYTE 8'h00
`define LEAD_FIRST 8'hFF
`define LEAD_NEXT 8'h00
`define ANC_FIRST 8'h00
`define ANC_NEXT 8'hFF
`define HID_CODES_MIN 6'h3E
`define HID_MSB_ONE 6'h3E

`define REMAP_LOW_IN 8'h00
`define REMAP_HIGH_IN 8'hFF
`define REMAP_LOW_OUT 8'h03
`define REMAP_HIGH_OUT 8'hFC

`define SEL_AE 3'h0
`define SEL_FILL 3'h1
`define SEL_AF 3'h2
`define SEL_OVF 3'h3
`define SEL_MARK 3'h4

// code kinds, then codes indexed by msb and field id
`define KIND_SAV_ACT 2'h0
`define KIND_EAV_ACT 2'h1
`define KIND_SAV_BLK 2'h2
`define KIND_EAV_BLK 2'h3
`define TRC_SAV_ACT_00 8'h0E
`define TRC_SAV_ACT_01 8'h49
`define TRC_SAV_ACT_10 8'h80
`define TRC_SAV_ACT_11 8'hC7
`define TRC_EAV_ACT_00 8'h13
`define TRC_EAV_ACT_01 8'h54
`define TRC_EAV_ACT_10 8'h9D
`define TRC_EAV_ACT_11 8'hDA
`define TRC_SAV_BLK_00 8'h25
`define TRC_SAV_BLK_01 8'h62
`define TRC_SAV_BLK_10 8'hAB
`define TRC_SAV_BLK_11 8'hEC
`define TRC_EAV_BLK_00 8'h38
`define TRC_EAV_BLK_01 8'h7F
`define TRC_EAV_BLK_10 8'hB6
`define TRC_EAV_BLK_11 8'hF1

`endif

// >>> ip_asserts.sv
/*
  concurrent checks on the ports of the image port output stage.
  assumes a single mclk domain with srst synchronous, bound at the foot of this file.
*/
`timescale 1ns/1ns
module ip_checker (
  input wire mclk,
  input wire srst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire [7:0] reg_rdata_ff,
  input wire ext_clk_mode,
  input wire gate_use,
  input wire external_gate_input,
  input wire ref_pulse_mode,
  input wire [2:0] pin_a_sel,
  input wire [4:0] out_invert,
  input wire [7:0] pdata_ff,
  input wire output_qualifier_pin,
  input wire horizontal_ref_pin,
  input wire vertical_ref_pin,
  input wire general_output_pin_a,
  input wire general_output_pin_b
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  a_idle_zero: assert property (!$past(out_invert[0]) && !output_qualifier_pin |-> pdata_ff == 8'h00)
    else $error("idle cycle carries a nonzero byte");
  a_gate_hold: assert property ((gate_use && !external_gate_input && !out_invert[0]) [*5] |-> !output_qualifier_pin && pdata_ff == 8'h00)
    else $error("output advanced while held");
  a_pin_map: assert property ($past(reg_addr) == 8'h86 && $past(pin_a_sel) == 3'h3 && !$past(out_invert[3]) |-> general_output_pin_a == reg_rdata_ff[7])
    else $error("pin a does not show overflow");
  a_fill_rise: assert property ($past(reg_addr) == 8'h86 && $past(reg_addr, 2) == 8'h86 && $rose(reg_rdata_ff[5]) |-> reg_rdata_ff[6])
    else $error("combined flag set below almost full");
  a_fill_fall: assert property ($past(reg_addr) == 8'h86 && $past(reg_addr, 2) == 8'h86 && $fell(reg_rdata_ff[5]) |-> reg_rdata_ff[4])
    else $error("combined flag cleared above almost empty");
  a_href_pulse: assert property (!ext_clk_mode && !gate_use && ref_pulse_mode && !out_invert[1] && horizontal_ref_pin |=> !horizontal_ref_pin)
    else $error("horizontal pulse wider than one step");
  a_vref_in_href: assert property (!ref_pulse_mode && out_invert[2:1] == 2'b00 && vertical_ref_pin |-> horizontal_ref_pin)
    else $error("vertical gate outside horizontal gate");
  a_level_fields: assert property (reg_wr && reg_addr == 8'h86 ##1 reg_addr == 8'h86 |=> reg_rdata_ff[3:0] == $past(reg_wdata[3:0], 2))
    else $error("level fields not written");
  a_reset_pins: assert property (disable iff (1'b0) srst |=> pdata_ff == 8'h00 && !output_qualifier_pin && !horizontal_ref_pin && !vertical_ref_pin && !general_output_pin_a && !general_output_pin_b)
    else $error("outputs active after reset");
endmodule // ip_checker

bind image_port_fifo_and_reference_coding ip_checker i_chk (
  .mclk(mclk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rdata_ff(reg_rdata_ff), .ext_clk_mode(ext_clk_mode), .gate_use(gate_use),
  .external_gate_input(external_gate_input), .ref_pulse_mode(ref_pulse_mode),
  .pin_a_sel(pin_a_sel), .out_invert(out_invert), .pdata_ff(pdata_ff),
  .output_qualifier_pin(output_qualifier_pin), .horizontal_ref_pin(horizontal_ref_pin),
  .vertical_ref_pin(vertical_ref_pin), .general_output_pin_a(general_output_pin_a),
  .general_output_pin_b(general_output_pin_b)
);

// >>> fb_model.sv
/*
  frame buffer capture model: collects qualified bytes, makes the port clock and the gate.
  assumes the bench reads and empties the got queue.
*/
`timescale 1ns/1ns
module fb_model (
  input wire mclk,
  input wire [7:0] pdata,
  input wire qual,
  input wire run_clk,
  input wire hold,
  output reg port_clk,
  output wire gate
);
  logic [7:0] got[$];
  assign gate = !hold;
  initial port_clk = 1'b0;
  // clock stands low outside frames
  always #40 port_clk = run_clk ? !port_clk : 1'b0;
  // one capture per step: on mclk, or on port clock rises while it runs
  always @(posedge mclk) if (qual && !run_clk) got.push_back(pdata);
  always @(posedge port_clk) if (qual) got.push_back(pdata);
endmodule // fb_model

// >>> testbench.sv
/*
  self-checking bench of the image port output stage.
  assumes the design, its constants header, the capture model and the checker are compiled first.
*/
`timescale 1ns/1ns
module testbench;
  logic mclk = 1'b0, srst = 1'b1, reg_wr = 1'b0, ext_clk_mode = 1'b0, gate_use = 1'b0;
  logic codes_off = 1'b0, ref_pulse_mode = 1'b0, sliced_value_remap = 1'b0, video_code_msb = 1'b0;
  logic scl_first = 1'b0, scl_last = 1'b0, scl_fid = 1'b0, scl_vact = 1'b0, scl_lastline = 1'b0;
  logic scl_valid = 1'b0, txt_valid = 1'b0, txt_line_done = 1'b0, run_clk = 1'b0, hold = 1'b0;
  logic [7:0] reg_addr = 8'h86, reg_wdata = 8'h00, txt_byte = 8'h00;
  logic [5:0] hid = 6'h15;
  logic [2:0] pin_a_sel = 3'h3;
  logic [4:0] inv = 5'h00;
  logic [31:0] scl_dw = 32'h0000_0000;
  wire [7:0] rdata, pdata;
  wire scl_rdy, txt_rdy, qual, href, vref, pin_a, pin_b, port_clk, gate;
  int fail_count = 0, num_checks = 0, cyc = 0;
  logic [7:0] exp_q[$];
  // flags msb,fid,vact,lastline then start code and end code
  logic [19:0] rows[8] = '{20'h2_0E13, 20'h6_4954, 20'hA_809D, 20'hE_C7DA,
                           20'h0_2538, 20'h7_497F, 20'h8_ABB6, 20'hF_C7F1};
  image_port_fifo_and_reference_coding i_dut (
    .mclk(mclk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rdata_ff(rdata), .ext_clk_mode(ext_clk_mode), .port_clk(port_clk),
    .gate_use(gate_use), .external_gate_input(gate), .codes_off(codes_off),
    .ref_pulse_mode(ref_pulse_mode), .sliced_value_remap(sliced_value_remap),
    .sliced_header_identifier(hid), .video_code_msb(video_code_msb), .pin_a_sel(pin_a_sel),
    .pin_b_sel(3'h4), .out_invert(inv), .scl_dw(scl_dw), .scl_first(scl_first),
    .scl_last(scl_last), .scl_fid(scl_fid), .scl_vact(scl_vact), .scl_lastline(scl_lastline),
    .scl_valid(scl_valid), .scl_ready_ff(scl_rdy), .txt_byte(txt_byte), .txt_valid(txt_valid),
    .txt_line_done(txt_line_done), .txt_line_num(9'h011), .txt_std(4'h3), .txt_fid(1'b0),
    .txt_ready_ff(txt_rdy), .pdata_ff(pdata), .output_qualifier_pin(qual),
    .horizontal_ref_pin(href), .vertical_ref_pin(vref), .general_output_pin_a(pin_a),
    .general_output_pin_b(pin_b)
  );
  fb_model i_fb (.mclk(mclk), .pdata(pdata), .qual(qual), .run_clk(run_clk), .hold(hold),
    .port_clk(port_clk), .gate(gate));
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      close_out();
    end
  end
  task automatic tick(input int n = 1);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [7:0] d);
    reg_wdata = d;
    reg_wr = 1'b1;
    tick();
    reg_wr = 1'b0;
    tick(3);
  endtask
  task automatic send_line(input int n);
    for (int i = 0; i < n; i++) begin
      scl_dw = 32'h2423_2221 + 32'h0404_0404 * i;
      scl_first = (i == 0);
      scl_last = (i == n - 1);
      scl_valid = 1'b1;
      tick();
    end
    scl_valid = 1'b0;
    scl_first = 1'b0;
    scl_last = 1'b0;
  endtask
  task automatic send_text(input logic [7:0] a, b, c);
    logic [7:0] v[3];
    v = '{a, b, c};
    for (int t = 0; t < 100 && txt_rdy !== 1'b1; t++) tick();
    foreach (v[i]) begin
      txt_byte = v[i];
      txt_valid = 1'b1;
      tick();
    end
    txt_valid = 1'b0;
    txt_line_done = 1'b1;
    tick();
    txt_line_done = 1'b0;
  endtask
  task automatic chk_seq(input string what);
    for (int t = 0; t < 3000 && i_fb.got.size() < exp_q.size(); t++) tick();
    tick(20);
    check({what, " count"}, 8'(i_fb.got.size()), 8'(exp_q.size()));
    foreach (exp_q[i]) check(what, i_fb.got[i], exp_q[i]);
    i_fb.got.delete();
    $display("test %s done", what);
  endtask
  task automatic chk_line(input string what, input int n, input logic [7:0] sav, eav,
                          input bit codes);
    exp_q = {};
    if (codes) exp_q = {8'hFF, 8'h00, 8'h00, sav};
    for (int j = 0; j < 4 * n; j++) exp_q.push_back(8'h21 + 8'(j));
    if (codes) exp_q = {exp_q, 8'hFF, 8'h00, 8'h00, eav};
    chk_seq(what);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    tick(20);
    srst = 1'b0;
    tick(3);
    check("pins", {3'h0, qual, href, vref, pin_a, pin_b}, 8'h00);
    check("reset flags", rdata, 8'h10);
    foreach (rows[r]) begin
      {video_code_msb, scl_fid, scl_vact, scl_lastline} = rows[r][19:16];
      send_line(2);
      chk_line("line", 2, rows[r][15:8], rows[r][7:0], 1'b1);
    end
    sliced_value_remap = 1'b1;
    send_text(8'h00, 8'hFF, 8'h5A);
    exp_q = {8'h00, 8'hFF, 8'hFF, 8'h55, 8'h02, 8'h13, 8'h03, 8'hFC, 8'h5A};
    chk_seq("ancillary text");
    check("marker set", {7'h0, pin_b}, 8'h01);
    hid = 6'h3E;
    sliced_value_remap = 1'b0;
    send_text(8'h00, 8'hFF, 8'h5A);
    exp_q = {8'hFF, 8'h00, 8'h00, 8'hAB, 8'h02, 8'h13, 8'h00, 8'hFF, 8'h5A,
             8'hFF, 8'h00, 8'h00, 8'hB6};
    chk_seq("coded text");
    check("marker clear", {7'h0, pin_b}, 8'h00);
    codes_off = 1'b1;
    ref_pulse_mode = 1'b1;
    {video_code_msb, scl_fid, scl_vact, scl_lastline} = 4'b0010;
    send_line(2);
    chk_line("no codes", 2, 8'h00, 8'h00, 1'b0);
    codes_off = 1'b0;
    ref_pulse_mode = 1'b0;
    ext_clk_mode = 1'b1;
    run_clk = 1'b1;
    tick(10);
    send_line(2);
    chk_line("port clock", 2, 8'h0E, 8'h13, 1'b1);
    run_clk = 1'b0;
    ext_clk_mode = 1'b0;
    wr_reg(8'h0A);
    gate_use = 1'b1;
    hold = 1'b1;
    tick(4);
    send_line(32);
    tick(3);
    check("full flags", rdata, 8'h6A);
    check("ready", {7'h0, scl_rdy}, 8'h00);
    scl_valid = 1'b1;
    tick();
    scl_valid = 1'b0;
    tick(3);
    check("overflow", rdata, 8'hEA);
    check("pin a", {7'h0, pin_a}, 8'h01);
    wr_reg(8'h1A);
    check("overflow clear", rdata, 8'h6A);
    hold = 1'b0;
    chk_line("full fifo", 32, 8'h0E, 8'h13, 1'b1);
    check("drained", rdata, 8'h1A);
    gate_use = 1'b0;
    reg_addr = 8'h85;
    tick(2);
    check("unmapped", rdata, 8'h00);
    reg_addr = 8'h86;
    inv = 5'h1E;
    tick(3);
    check("polarity", {4'h0, href, vref, pin_a, pin_b}, 8'h0F);
    inv = 5'h00;
    srst = 1'b1;
    tick(4);
    srst = 1'b0;
    tick(3);
    check("reset again", rdata, 8'h10);
    $display("test registers, polarity and reset done");
    close_out();
  end
endmodule // testbench
